// >>> src/tdc_regs.vh
// Purpose: constants for trigger delay acquisition control
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes: included by tdc_trigger_ctrl.v
//
// How it works
// - Main trigger arms delay counter; it counts each word stored afterwards.
// - Main capture ends when delay count equals target; run stops, display.
// - D words after trigger; at most 256 minus D kept up to trigger.
// - Self-stop only when every triggered memory has triggered and reached delay.
// - Without timing extension every trigger execution raises trigger output.
// - Memory select 0 main, 1 timing; main only without extension.
// - Position code 0,1,2,3 loads 240,128,16,0 post-trigger words.
// - After capture halt select 0 lets target run, 1 asserts halt.
// - Qualification select 0 standard, 1 custom forms the state clock.
// - Trigger settings change only on explicit write, never by program edit.
// - Qualification choice applies even with no main trigger in program.
// - Program without trigger runs until operator start/stop request.
// - No main trigger means halt stays inactive when run stops.
// - Triggers while counting never restart count but still drive output.
// - No trigger: main only; timing only: timing; both: both acquire.
// - Post-trigger count fixed, pre-trigger count varies with prior stores.
// - Unstored trigger cycle marks last stored word, else first word.
// - Start/stop while running halts capture, ends run, enters display.
`ifndef TDC_REGS_VH
`define TDC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TDC_OFS_CTRL 6'h00
`define TDC_OFS_CFG 6'h04
`define TDC_OFS_STAT 6'h08
`define TDC_OFS_DCNT 6'h0C
`define TDC_OFS_MARK 6'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TDC_CTRL_START 0
`define TDC_CTRL_MAIN 1
`define TDC_CTRL_TIMING 2
`define TDC_CFG_POS_LO 0
`define TDC_CFG_HALT 2
`define TDC_CFG_QUAL 3
`define TDC_CFG_MEM 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TDC_CFG_RST 5'h00
`define TDC_CTRL_RST 2'h0

// ----------------------------------------
// Post-trigger word counts
// ----------------------------------------
`define TDC_POST_BEFORE 8'hF0
`define TDC_POST_CENTER 8'h80
`define TDC_POST_AFTER 8'h10
`define TDC_POST_ZERO 8'h00
`define TDC_MEM_DEPTH 9'h100

`endif

// >>> src/tdc_sync2.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one destination clock
// Notes: first stage read only by the second
`timescale 1ns/1ps
module tdc_sync2 #(
	parameter W = 1
) (
	// Clock and reset
	input wire i_clk,
	input wire i_nrst,
	// Data
	input wire [W-1:0] i_d,
	output wire [W-1:0] o_q
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;

always @(posedge i_clk) begin
	if (!i_nrst) begin
		meta_r <= {W{1'b0}};
		sync_r <= {W{1'b0}};
	end else begin
		meta_r <= i_d;
		sync_r <= meta_r;
	end
end

assign o_q = sync_r;

endmodule

// >>> src/tdc_trigger_ctrl.v
// Purpose: trigger and post-trigger delay control of the capture memory
// Assumes: sequencer and timing unit on i_clk; target pins asynchronous
// Notes: capture memory is external; this block drives its write port
`timescale 1ns/1ps
`include "tdc_regs.vh"
module tdc_trigger_ctrl #(
	parameter DW = 30,
	parameter AW = 8,
	parameter TIMING_FITTED = 1'b0
) (
	// Clock and reset
	input wire i_clk,
	input wire i_nrst,
	// Avalon-MM slave
	input wire [5:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [3:0] i_byteenable,
	output wire o_waitrequest,
	output reg [31:0] o_readdata,
	// Target pins
	input wire i_tgt_clk_raw,
	input wire i_custom_qual,
	input wire [DW-1:0] i_tgt_data,
	output reg o_halt_tgt,
	// Program sequencer
	input wire i_trig_exec,
	input wire i_store_qual,
	input wire i_timing_done,
	// Capture memory and status
	output reg o_mem_we,
	output reg [AW-1:0] o_mem_addr,
	output reg [DW-1:0] o_mem_wdata,
	output wire o_main_acq_en,
	output wire o_timing_acq_en,
	output wire o_qual_sel,
	output reg o_ext_trig,
	output wire o_running
);

// ----------------------------------------
// Local functions
// ----------------------------------------
function [7:0] post_words;
	input [1:0] code;
	begin
		case (code)
			2'h0: post_words = `TDC_POST_BEFORE;
			2'h1: post_words = `TDC_POST_CENTER;
			2'h2: post_words = `TDC_POST_AFTER;
			2'h3: post_words = `TDC_POST_ZERO;
			default: post_words = `TDC_POST_ZERO;
		endcase
	end
endfunction

// ----------------------------------------
// Run states
// ----------------------------------------
localparam ST_DISPLAY = 1'b0;
localparam ST_RUN = 1'b1;

// ----------------------------------------
// Declarations
// ----------------------------------------
reg ack_r;
reg [4:0] cfg_r;
reg main_prog_r;
reg timing_prog_r;
reg state_r;
reg state_nxt;
reg armed_r;
reg [7:0] dcnt_r;
reg [AW-1:0] waddr_r;
reg [AW-1:0] mark_r;
reg [8:0] nstored_r;
reg clk_prev_r;
reg start_req;
wire [1:0] pin_sync;
wire [DW-1:0] data_sync;
wire clk_sync;
wire qual_sync;
wire state_clk;
wire store;
wire rd_go;
wire wr_go;
wire [7:0] target;
wire timing_eff;
wire main_trig;
wire main_done;
wire need_main;
wire need_timing;
wire all_done;
wire fitted;
reg [7:0] waddr_lane;
reg [7:0] mark_lane;

assign fitted = (TIMING_FITTED != 0);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
tdc_sync2 #(
	.W(2)
) u_pin_sync (
	.i_clk(i_clk),
	.i_nrst(i_nrst),
	.i_d({i_custom_qual, i_tgt_clk_raw}),
	.o_q(pin_sync)
);

tdc_sync2 #(
	.W(DW)
) u_data_sync (
	.i_clk(i_clk),
	.i_nrst(i_nrst),
	.i_d(i_tgt_data),
	.o_q(data_sync)
);

assign clk_sync = pin_sync[0];
assign qual_sync = pin_sync[1];

// ----------------------------------------
// State clock qualification
// ----------------------------------------
// Edge taken from the synchronised copy, so target clock is limited
// to well under half of i_clk.
always @(posedge i_clk) begin
	if (!i_nrst) begin
		clk_prev_r <= 1'b0;
	end else begin
		clk_prev_r <= clk_sync;
	end
end

// Choice stays in force with or without a main trigger in the program
assign o_qual_sel = cfg_r[`TDC_CFG_QUAL];
assign state_clk = clk_sync & ~clk_prev_r & (~o_qual_sel | qual_sync);

// ----------------------------------------
// Avalon-MM slave
// ----------------------------------------
// One wait cycle on every access keeps read data registered.
assign o_waitrequest = (i_read | i_write) & ~ack_r;
assign rd_go = i_read & ~ack_r;
assign wr_go = i_write & ack_r;

// Pointers widened to their byte lanes so a narrower AW still reads back
always @* begin
	waddr_lane = 8'h00;
	mark_lane = 8'h00;
	waddr_lane[AW-1:0] = waddr_r;
	mark_lane[AW-1:0] = mark_r;
end

always @(posedge i_clk) begin
	if (!i_nrst) begin
		ack_r <= 1'b0;
	end else begin
		ack_r <= (i_read | i_write) & ~ack_r;
	end
end

always @(posedge i_clk) begin
	if (!i_nrst) begin
		o_readdata <= 32'h0000_0000;
	end else if (rd_go) begin
		case (i_address)
			`TDC_OFS_CTRL: begin
				o_readdata <= {29'h0000_0000, timing_prog_r, main_prog_r, 1'b0};
			end
			`TDC_OFS_CFG: begin
				o_readdata <= {27'h000_0000, cfg_r};
			end
			`TDC_OFS_STAT: begin
				o_readdata <= {25'h000_0000, fitted, o_ext_trig, o_halt_tgt,
					i_timing_done, main_done, armed_r, state_r};
			end
			`TDC_OFS_DCNT: begin
				o_readdata <= {8'h00, target, 8'h00, dcnt_r};
			end
			`TDC_OFS_MARK: begin
				o_readdata <= {7'h00, nstored_r, waddr_lane, mark_lane};
			end
			default: begin
				o_readdata <= 32'h0000_0000;
			end
		endcase
	end
end

// ----------------------------------------
// Control and trigger settings
// ----------------------------------------
// Settings only move on an explicit write; program edits leave them alone.
always @(posedge i_clk) begin
	if (!i_nrst) begin
		cfg_r <= `TDC_CFG_RST;
		main_prog_r <= 1'b0;
		timing_prog_r <= 1'b0;
	end else if (wr_go && i_byteenable[0]) begin
		if (i_address == `TDC_OFS_CFG) begin
			cfg_r <= i_writedata[4:0];
		end
		if (i_address == `TDC_OFS_CTRL) begin
			main_prog_r <= i_writedata[`TDC_CTRL_MAIN];
			timing_prog_r <= i_writedata[`TDC_CTRL_TIMING];
		end
	end
end

always @* begin
	start_req = wr_go && i_byteenable[0] && (i_address == `TDC_OFS_CTRL) &&
		i_writedata[`TDC_CTRL_START];
end

// ----------------------------------------
// Memory use and trigger routing
// ----------------------------------------
assign target = post_words(cfg_r[1:0]);
assign timing_eff = fitted & timing_prog_r;
assign o_main_acq_en = (state_r == ST_RUN) & (main_prog_r | ~timing_eff);
assign o_timing_acq_en = (state_r == ST_RUN) & timing_eff;
// Main target unless extension fitted and timing selected
assign main_trig = i_trig_exec & (state_r == ST_RUN) &
	~(fitted & cfg_r[`TDC_CFG_MEM]);
assign store = o_main_acq_en & state_clk & i_store_qual;

// ----------------------------------------
// Completion
// ----------------------------------------
assign main_done = armed_r & (dcnt_r == target);
assign need_main = main_prog_r;
assign need_timing = timing_eff;
// No trigger in the program: only the operator ends the run
assign all_done = (need_main | need_timing) &
	(~need_main | main_done) & (~need_timing | i_timing_done);

always @* begin
	state_nxt = state_r;
	case (state_r)
		ST_DISPLAY: begin
			if (start_req) begin
				state_nxt = ST_RUN;
			end
		end
		ST_RUN: begin
			if (start_req || all_done) begin
				state_nxt = ST_DISPLAY;
			end
		end
		default: begin
			state_nxt = ST_DISPLAY;
		end
	endcase
end

always @(posedge i_clk) begin
	if (!i_nrst) begin
		state_r <= ST_DISPLAY;
	end else begin
		state_r <= state_nxt;
	end
end

assign o_running = state_r;

// ----------------------------------------
// Delay counter and trigger mark
// ----------------------------------------
always @(posedge i_clk) begin
	if (!i_nrst) begin
		armed_r <= 1'b0;
		dcnt_r <= 8'h00;
		mark_r <= {AW{1'b0}};
	end else if (state_r == ST_DISPLAY && start_req) begin
		armed_r <= 1'b0;
		dcnt_r <= 8'h00;
		mark_r <= {AW{1'b0}};
	end else if (state_r == ST_RUN) begin
		if (main_trig && !armed_r) begin
			armed_r <= 1'b1;
			// Trigger word itself belongs to the pre-trigger part
			if (store) begin
				mark_r <= waddr_r;
			end else if (nstored_r != 9'h000) begin
				mark_r <= waddr_r - {{(AW-1){1'b0}}, 1'b1};
			end else begin
				mark_r <= {AW{1'b0}};
			end
		end else if (armed_r && store && !main_done) begin
			dcnt_r <= dcnt_r + 8'h01;
		end
	end
end

// ----------------------------------------
// Capture memory write port
// ----------------------------------------
// Circular 256-word memory: older pre-trigger words are overwritten,
// so at most 256 minus D stay up to the trigger word.
always @(posedge i_clk) begin
	if (!i_nrst) begin
		waddr_r <= {AW{1'b0}};
		nstored_r <= 9'h000;
		o_mem_we <= 1'b0;
		o_mem_addr <= {AW{1'b0}};
		o_mem_wdata <= {DW{1'b0}};
	end else begin
		o_mem_we <= 1'b0;
		if (state_r == ST_DISPLAY && start_req) begin
			waddr_r <= {AW{1'b0}};
			nstored_r <= 9'h000;
		end else if (store && !main_done) begin
			o_mem_we <= 1'b1;
			o_mem_addr <= waddr_r;
			o_mem_wdata <= data_sync;
			waddr_r <= waddr_r + {{(AW-1){1'b0}}, 1'b1};
			if (nstored_r != `TDC_MEM_DEPTH) begin
				nstored_r <= nstored_r + 9'h001;
			end
		end
	end
end

// ----------------------------------------
// Trigger output and target halt
// ----------------------------------------
// Trigger output holds high until the next program start.
always @(posedge i_clk) begin
	if (!i_nrst) begin
		o_ext_trig <= 1'b0;
	end else if (state_r == ST_DISPLAY && start_req) begin
		o_ext_trig <= 1'b0;
	end else if (!fitted && i_trig_exec && state_r == ST_RUN) begin
		o_ext_trig <= 1'b1;
	end
end

// Halt needs a main trigger present at the time the run ends
always @(posedge i_clk) begin
	if (!i_nrst) begin
		o_halt_tgt <= 1'b0;
	end else if (state_r == ST_DISPLAY && start_req) begin
		o_halt_tgt <= 1'b0;
	end else if (state_r == ST_RUN && state_nxt == ST_DISPLAY) begin
		o_halt_tgt <= main_prog_r & main_done & cfg_r[`TDC_CFG_HALT];
	end
end

endmodule

// >>> test/tdc_trig_chk_assertions.sv
// Purpose: port checks of the trigger delay control
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the ports of the top module
`timescale 1ns/1ps
module tdc_trig_chk #(
	parameter TIMING_FITTED = 1'b0
) (
	// Clock and reset
	input wire i_clk,
	input wire i_nrst,
	// Bus
	input wire [5:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [3:0] i_byteenable,
	input wire o_waitrequest,
	// Trigger and capture
	input wire i_trig_exec,
	input wire o_mem_we,
	input wire o_halt_tgt,
	input wire o_ext_trig,
	input wire o_running
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	wire ctl_wr = i_write && !o_waitrequest && i_address == 6'h00;
	wire go_wr = ctl_wr && i_byteenable[0] && i_writedata[0];
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	wait_one_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("wait longer than one cycle");
	idle_nowait_a: assert property (!(i_read || i_write) |-> !o_waitrequest)
		else $error("wait with no request");
	we_pulse_a: assert property (o_mem_we |=> !o_mem_we)
		else $error("write pulse too long");
	we_run_a: assert property (o_mem_we |-> $past(o_running))
		else $error("store outside a run");
	ext_set_a: assert property (!TIMING_FITTED && i_trig_exec && o_running |=> o_ext_trig)
		else $error("trigger out not raised");
	ext_hold_a: assert property (o_ext_trig && !ctl_wr |=> o_ext_trig)
		else $error("trigger out dropped");
	halt_hold_a: assert property (o_halt_tgt && !ctl_wr |=> o_halt_tgt)
		else $error("halt dropped");
	halt_idle_a: assert property (o_halt_tgt |-> !o_running)
		else $error("halt while running");
	stop_req_a: assert property (o_running && go_wr |=> !o_running)
		else $error("stop request ignored");
	start_req_a: assert property (!o_running && go_wr |=> o_running)
		else $error("start request ignored");
endmodule
bind tdc_trigger_ctrl tdc_trig_chk #(.TIMING_FITTED(TIMING_FITTED)) chk_u (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
	.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
	.o_waitrequest(o_waitrequest), .i_trig_exec(i_trig_exec), .o_mem_we(o_mem_we),
	.o_halt_tgt(o_halt_tgt), .o_ext_trig(o_ext_trig), .o_running(o_running)
);

// >>> test/tdc_target_model.sv
// Purpose: target system seen through the probe
// Assumes: raw clock from i_clk, each phase HALF cycles
// Notes: a halted target stops its clock
`timescale 1ns/1ps
module tdc_target_model #(
	parameter DW = 30,
	parameter HALF = 3
) (
	// Clock and reset
	input wire i_clk,
	input wire i_nrst,
	// Target pins
	input wire i_halt,
	output reg o_clk_raw,
	output reg o_custom_qual,
	output reg [DW-1:0] o_data
);
	// ----------------------------------------
	// Clock and data
	// ----------------------------------------
	integer ph_r;
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			ph_r <= 0;
			o_clk_raw <= 1'b0;
			o_custom_qual <= 1'b0;
			o_data <= {DW{1'b0}};
		end else if (!i_halt) begin
			ph_r <= (ph_r == HALF - 1) ? 0 : ph_r + 1;
			if (ph_r == HALF - 1) begin
				o_clk_raw <= !o_clk_raw;
				// New word every raw cycle so no two of 60 consecutive samples match
				if (!o_clk_raw) begin
					o_data <= {o_data[DW-2:0], ~o_data[DW-1]};
					// Custom qualifier passes one raw rising edge in two
					o_custom_qual <= !o_custom_qual;
				end
			end
		end
	end
endmodule

// >>> test/trigger_delay_acquisition_control_test.sv
// Purpose: bench for the trigger delay control
// Assumes: no timing extension fitted
// Notes: sequencer pulses come from the bench
`timescale 1ns/1ps
module trigger_delay_acquisition_control_test;
	reg i_clk = 1'b0;
	reg i_nrst = 1'b0;
	reg [5:0] i_address = 6'h00;
	reg i_read = 1'b0;
	reg i_write = 1'b0;
	reg [31:0] i_writedata = 32'h0;
	reg i_trig_exec = 1'b0;
	reg i_store_qual = 1'b0;
	reg [3:0] i_byteenable = 4'hF;
	reg i_timing_done = 1'b0;
	wire o_waitrequest, raw, cq, o_halt_tgt, o_mem_we, o_main_acq_en, o_timing_acq_en;
	wire o_qual_sel, o_ext_trig, o_running;
	wire [31:0] o_readdata;
	wire [29:0] tdata;
	wire [7:0] o_mem_addr;
	wire [29:0] o_mem_wdata;
	integer miscompares = 0;
	integer n_checks = 0;
	integer nwe = 0;
	integer cyc = 0;
	integer i;
	integer ns;
	reg [31:0] rd;
	always #5 i_clk = ~i_clk;
	tdc_trigger_ctrl #(.DW(30), .AW(8), .TIMING_FITTED(1'b0)) dut_u (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_waitrequest(o_waitrequest), .o_readdata(o_readdata), .i_tgt_clk_raw(raw),
		.i_custom_qual(cq), .i_tgt_data(tdata), .o_halt_tgt(o_halt_tgt),
		.i_trig_exec(i_trig_exec), .i_store_qual(i_store_qual), .i_timing_done(i_timing_done),
		.o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
		.o_main_acq_en(o_main_acq_en), .o_timing_acq_en(o_timing_acq_en),
		.o_qual_sel(o_qual_sel), .o_ext_trig(o_ext_trig), .o_running(o_running)
	);
	tdc_target_model #(.DW(30), .HALF(3)) tgt_u (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_halt(o_halt_tgt),
		.o_clk_raw(raw), .o_custom_qual(cq), .o_data(tdata)
	);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task conclude;
		begin
			$display("checks=%0d miscompares=%0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// Whole run needs about 3000 cycles
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_mem_we === 1'b1)
			nwe <= nwe + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			conclude;
		end
	end
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task bus(input wr, input [5:0] a, input [31:0] d);
		begin
			i_address <= a;
			i_writedata <= d;
			i_write <= wr;
			i_read <= !wr;
			@(posedge i_clk);
			while (o_waitrequest !== 1'b0)
				@(posedge i_clk);
			rd = o_readdata;
			i_write <= 1'b0;
			i_read <= 1'b0;
			@(posedge i_clk);
		end
	endtask
	function [31:0] tgt(input [1:0] c);
		tgt = (c == 2'h0) ? 32'hF0 : (c == 2'h1) ? 32'h80 : (c == 2'h2) ? 32'h10 : 32'h0;
	endfunction
	task pulse;
		begin
			i_trig_exec <= 1'b1;
			@(posedge i_clk);
			i_trig_exec <= 1'b0;
		end
	endtask
	// Trigger falls on an unstored cycle after c stored words
	task cap(input [1:0] c, input h);
		integer n0, k;
		begin
			bus(1'b1, 6'h04, {29'h0, h, c});
			bus(1'b1, 6'h00, 32'h3);
			n0 = nwe;
			// Code 0 stores nothing first, so the qualifier is not raised before the trigger
			if (c != 2'h0) begin
				i_store_qual <= 1'b1;
				for (k = 0; k < 100 && nwe < n0 + c; k = k + 1)
					@(posedge i_clk);
				i_store_qual <= 1'b0;
			end
			repeat (12) @(posedge i_clk);
			chk(nwe - n0, c);
			n0 = nwe;
			pulse;
			i_store_qual <= 1'b1;
			repeat (20) @(posedge i_clk);
			pulse;
			for (k = 0; k < 3000 && o_running !== 1'b0; k = k + 1)
				@(posedge i_clk);
			repeat (8) @(posedge i_clk);
			chk(nwe - n0, tgt(c));
			chk(o_halt_tgt, h);
			chk(o_ext_trig, 1'b1);
			bus(1'b0, 6'h0C, 32'h0);
			chk(rd[7:0], tgt(c));
			chk(rd[23:16], tgt(c));
			bus(1'b0, 6'h10, 32'h0);
			chk(rd[7:0], (c == 2'h0) ? 0 : c - 1);
			chk(rd[24:16], c + tgt(c));
			chk(rd[15:8], c + tgt(c));
			chk(o_mem_addr, c + tgt(c) - 1);
			// Halted target freezes its bus on the last stored word
			if (c == 2'h1)
				chk(o_mem_wdata, tdata);
			i_store_qual <= 1'b0;
			$display("capture code %0d done", c);
		end
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		bus(1'b0, 6'h04, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 6'h08, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 6'h14, 32'h0);
		chk(rd, 32'h0);
		i_byteenable <= 4'h0;
		bus(1'b1, 6'h04, 32'h1F);
		i_byteenable <= 4'hF;
		bus(1'b0, 6'h04, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		for (i = 0; i < 4; i = i + 1)
			cap(i[1:0], i[0]);
		// Halt and custom qualification chosen, zero delay, no main trigger in program
		bus(1'b1, 6'h04, 32'h0F);
		bus(1'b1, 6'h00, 32'h1);
		ns = nwe;
		i_store_qual <= 1'b1;
		i_timing_done <= 1'b1;
		repeat (120) @(posedge i_clk);
		// One raw edge in two qualifies: about ten stores, not twenty
		chk((nwe - ns >= 9) && (nwe - ns <= 11), 1'b1);
		pulse;
		repeat (20) @(posedge i_clk);
		chk(o_running, 1'b1);
		chk(o_qual_sel, 1'b1);
		chk(o_main_acq_en, 1'b1);
		chk(o_timing_acq_en, 1'b0);
		bus(1'b0, 6'h08, 32'h0);
		chk(rd[6:0], 7'h2F);
		bus(1'b1, 6'h00, 32'h1);
		repeat (2) @(posedge i_clk);
		chk(o_running, 1'b0);
		chk(o_halt_tgt, 1'b0);
		i_timing_done <= 1'b0;
		bus(1'b0, 6'h04, 32'h0);
		chk(rd, 32'h0F);
		bus(1'b1, 6'h04, 32'h0);
		chk(o_qual_sel, 1'b0);
		$display("no trigger test done");
		conclude;
	end
endmodule
